// ===== verilog/mamp_regs.sv
/*
 * Monitor warning status, password entry, table selector, table-one
 * user EEPROM regions and alarm-enable masks with the interrupt and
 * shutdown gating they drive. Assumes byte strobes from an I2C slave
 * front end, synchronous inputs and nonvolatile values supplied by the
 * surrounding memory controller.
 */
//
// Function
// - Status bits 7/6 show monitor-3 high/low warning of last measurement.
// - Status bits 5/4 show monitor-4 high/low warning of last measurement.
// - Reserved gap bytes 76h-7Ah read zero; writes ignored.
// - Four-byte password entry at 7Bh-7Eh, first byte most significant.
// - Two privilege levels; higher includes every right of lower.
// - Password references live in nonvolatile storage reachable by higher level.
// - Password entry powers up as all ones, granting no privilege.
// - Password entry is write-only; reads return zero.
// - Table selector picks the upper table; readable and writable by all.
// - Table selector loads its power-on value from table two at start.
// - Region A 80h-BFh gated by higher privilege or region-A rights.
// - Region B C0h-F7h gated by higher privilege or region-B rights.
// - Alarm-enable bytes gated by region-C rights; shadowed nonvolatile.
// - First enable byte gates environment alarms onto transmit fault.
// - Second enable byte bits 7-4 gate monitor-3/4 alarms; rest reserved.
// - Third byte bits 3,1,0 gate fast alarms onto laser shutdown.
// - Fourth byte bits 7,6 gate signal-loss alarms onto transmit fault.
// - Fourth byte bit 3 gates maximum-bias alarm onto laser shutdown.
// - Enable bytes sit in table 01h or 05h per mask-location bit.
// - Transmit fault ORs enabled alarms, warnings and four unmaskable alarms.
`timescale 1ns/1ps

module mamp_regs #(
  parameter int EEPROM_DEPTH = 120
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Byte access from the serial slave port
  input wire mamp_pkg::mamp_req_type i_req,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  // Nonvolatile settings held elsewhere
  input wire logic [31:0] i_lower_privilege_password,
  input wire logic [31:0] i_higher_privilege_password,
  input wire logic [7:0] i_table_select_poweron_value,
  input wire logic i_mask_location,
  input wire mamp_pkg::mamp_rights_type i_rights,
  input wire logic [15:0] i_warning_enable,
  // Measurement results and alarms
  input wire logic i_meas_valid,
  input wire mamp_pkg::mamp_mon34_type i_mon34_flags,
  input wire mamp_pkg::mamp_alarms_type i_alarms,
  // Block outputs
  output logic o_transmit_fault_interrupt,
  output logic o_laser_shutdown_gate,
  output logic [1:0] o_privilege,
  output logic [7:0] o_upper_table_selector,
  output logic o_mask_nv_write
);

  // Index is the low seven address bits, so only this depth fits
  if (EEPROM_DEPTH != mamp_pkg::EEPROM_BYTES) begin : g_bad_depth
    $error("EEPROM_DEPTH must match the two table-one regions");
  end

  logic [7:0] status_q;
  logic [31:0] entry_q;
  logic [7:0] sel_q;
  logic init_done_q;
  mamp_pkg::mamp_priv_type priv_q;
  mamp_pkg::mamp_masks_type masks_q;
  logic [7:0] eeprom_q [0:EEPROM_DEPTH-1];
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic txf_q;
  logic shut_q;
  logic mask_wr_q;

  // Address decode
  wire [7:0] addr = i_req.addr;
  wire is_upper = addr[7];
  wire [6:0] ee_idx = addr[6:0];
  wire sel_table_one = (sel_q == mamp_pkg::TABLE_ONE);
  wire [7:0] mask_table = i_mask_location ? mamp_pkg::TABLE_MASK_ALT
                                          : mamp_pkg::TABLE_ONE;
  wire hit_status = (addr == mamp_pkg::WARN_STATUS_ADDR);
  wire hit_entry = (addr >= mamp_pkg::ENTRY_FIRST_ADDR) &&
                   (addr <= mamp_pkg::ENTRY_LAST_ADDR);
  wire hit_sel = (addr == mamp_pkg::TABLE_SEL_ADDR);
  wire hit_a = is_upper && sel_table_one &&
               (addr <= mamp_pkg::REGION_A_LAST);
  wire hit_b = sel_table_one && (addr >= mamp_pkg::REGION_B_FIRST) &&
               (addr <= mamp_pkg::REGION_B_LAST);
  wire hit_mask = (sel_q == mask_table) &&
                  (addr >= mamp_pkg::MASK_ENV_ADDR) &&
                  (addr <= mamp_pkg::MASK_SIGBIAS_ADDR);

  // Access rights; higher privilege always covers lower
  wire is_high = (priv_q == mamp_pkg::PRIV_HIGHER);
  wire is_low = (priv_q == mamp_pkg::PRIV_LOWER);
  wire rd_a = is_high || (is_low && (i_rights.a_read ||
              i_rights.a_readwrite));
  wire wr_a = is_high || (is_low && i_rights.a_readwrite);
  wire rd_b = is_high || (is_low && (i_rights.b_read ||
              i_rights.b_readwrite));
  wire wr_b = is_high || (is_low && i_rights.b_readwrite);
  wire rd_c = is_high || (is_low && (i_rights.c_read ||
              i_rights.c_readwrite));
  wire wr_c = is_high || (is_low && i_rights.c_readwrite);

  wire ee_we = i_req.wr && ((hit_a && wr_a) || (hit_b && wr_b));
  wire mask_we = i_req.wr && hit_mask && wr_c;
  wire entry_we = i_req.wr && hit_entry;
  wire sel_we = i_req.wr && hit_sel;
  wire [1:0] entry_byte = 2'(addr - mamp_pkg::ENTRY_FIRST_ADDR);
  wire [1:0] mask_byte = 2'(addr - mamp_pkg::MASK_ENV_ADDR);

  // Read mux; denied, reserved and write-only bytes read zero
  logic [7:0] mask_rd;
  always_comb begin
    case (mask_byte)
      2'd0: mask_rd = masks_q.env;
      2'd1: mask_rd = masks_q.mon34;
      2'd2: mask_rd = masks_q.fast_tx;
      default: mask_rd = masks_q.signal_bias;
    endcase
  end
  wire [7:0] rd_mux =
    hit_status ? status_q :
    hit_sel ? sel_q :
    (hit_a && rd_a) ? eeprom_q[ee_idx] :
    (hit_b && rd_b) ? eeprom_q[ee_idx] :
    (hit_mask && rd_c) ? mask_rd :
    mamp_pkg::READ_ZERO;

  // Privilege from password match, highest level first
  wire match_high = (entry_q == i_higher_privilege_password);
  wire match_low = (entry_q == i_lower_privilege_password);
  wire mamp_pkg::mamp_priv_type priv_d =
    match_high ? mamp_pkg::PRIV_HIGHER :
    match_low ? mamp_pkg::PRIV_LOWER : mamp_pkg::PRIV_NONE;

  // Interrupt and shutdown gating
  wire env_hit = |(i_alarms.env_alarm & masks_q.env);
  wire mon34_hit = |(i_alarms.mon34_alarm & masks_q.mon34[7:4]);
  wire los_hit =
    (i_alarms.signal_loss_high_alarm &
     masks_q.signal_bias[mamp_pkg::SB_SIGLOSS_HIGH_BIT]) |
    (i_alarms.signal_loss_low_alarm &
     masks_q.signal_bias[mamp_pkg::SB_SIGLOSS_LOW_BIT]);
  wire warn_hit = |(i_alarms.env_warning & i_warning_enable[15:8]) |
                  |(status_q[7:4] & i_warning_enable[7:4]);
  wire unmaskable = i_alarms.tx_power_high_alarm |
                    i_alarms.tx_power_low_alarm |
                    i_alarms.bias_max_alarm |
                    i_alarms.high_bias_fast_alarm;
  wire txf_d = env_hit | mon34_hit | los_hit | warn_hit |
               unmaskable;
  wire shut_d =
    (i_alarms.high_bias_fast_alarm &
     masks_q.fast_tx[mamp_pkg::FAST_HIGH_BIAS_BIT]) |
    (i_alarms.tx_power_high_alarm &
     masks_q.fast_tx[mamp_pkg::FAST_POWER_HIGH_BIT]) |
    (i_alarms.tx_power_low_alarm &
     masks_q.fast_tx[mamp_pkg::FAST_POWER_LOW_BIT]) |
    (i_alarms.bias_max_alarm &
     masks_q.signal_bias[mamp_pkg::SB_BIAS_MAX_BIT]);

  // Warning status captured per completed measurement
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      status_q <= mamp_pkg::WARN_STATUS_RESET;
    end else if (i_meas_valid) begin
      status_q <= {i_mon34_flags, 4'h0};
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      entry_q <= mamp_pkg::ENTRY_RESET;
    end else if (entry_we) begin
      entry_q[8*(3-entry_byte) +: 8] <= i_req.wdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      priv_q <= mamp_pkg::PRIV_NONE;
    end else begin
      priv_q <= priv_d;
    end
  end

  // Power-on table is caught after reset release, not under it
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      init_done_q <= 1'b0;
      sel_q <= 8'h00;
    end else if (!init_done_q) begin
      init_done_q <= 1'b1;
      sel_q <= i_table_select_poweron_value;
    end else if (sel_we) begin
      sel_q <= i_req.wdata;
    end
  end

  // Shadow copy; o_mask_nv_write asks the EE controller to persist it
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      masks_q <= {4{mamp_pkg::MASK_RESET}};
      mask_wr_q <= 1'b0;
    end else begin
      mask_wr_q <= mask_we;
      if (mask_we) begin
        case (mask_byte)
          2'd0: masks_q.env <= i_req.wdata & mamp_pkg::MASK_ENV_WMASK;
          2'd1: masks_q.mon34 <= i_req.wdata & mamp_pkg::MASK_MON34_WMASK;
          2'd2: masks_q.fast_tx <= i_req.wdata & mamp_pkg::MASK_FAST_WMASK;
          default: masks_q.signal_bias <=
            i_req.wdata & mamp_pkg::MASK_SIGBIAS_WMASK;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      for (int i = 0; i < EEPROM_DEPTH; i++) begin
        eeprom_q[i] <= mamp_pkg::EEPROM_RESET;
      end
    end else if (ee_we) begin
      eeprom_q[ee_idx] <= i_req.wdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= i_req.rd;
      if (i_req.rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      txf_q <= 1'b0;
      shut_q <= 1'b0;
    end else begin
      txf_q <= txf_d;
      shut_q <= shut_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_rvalid = rvalid_q;
  assign o_transmit_fault_interrupt = txf_q;
  assign o_laser_shutdown_gate = shut_q;
  assign o_privilege = priv_q;
  assign o_upper_table_selector = sel_q;
  assign o_mask_nv_write = mask_wr_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  sequence s_entry_first_write;
    i_req.wr && (i_req.addr == mamp_pkg::ENTRY_FIRST_ADDR);
  endsequence

  a_mon3_status_capture: assert property (
    i_meas_valid |=> status_q[7:6] == $past(i_mon34_flags[3:2]))
    else $error("monitor-3 warning bits not captured");

  a_mon4_status_capture: assert property (
    i_meas_valid |=> status_q[5:4] == $past(i_mon34_flags[1:0])
                     && status_q[3:0] == 4'h0)
    else $error("monitor-4 warning bits not captured");

  a_gap_reads_zero: assert property (
    i_req.rd && addr >= mamp_pkg::GAP_FIRST_ADDR &&
    addr <= mamp_pkg::GAP_LAST_ADDR |=> o_rvalid && o_rdata == 8'h00)
    else $error("reserved gap byte read nonzero");

  a_entry_msb_first: assert property (
    s_entry_first_write |=> entry_q[31:24] == $past(i_req.wdata))
    else $error("password first byte not in top bits");

  a_entry_read_zero: assert property (
    i_req.rd && hit_entry |=> o_rdata == 8'h00)
    else $error("password entry byte readable");

  a_priv_highest_match: assert property (
    match_high |=> o_privilege == mamp_pkg::PRIV_HIGHER)
    else $error("higher match did not grant higher privilege");

  a_selector_write: assert property (
    init_done_q && sel_we ##1 !sel_we [*2] |->
    o_upper_table_selector == $past(i_req.wdata, 2))
    else $error("table selector lost written value");

  a_selector_poweron: assert property (
    $rose(init_done_q) |->
    sel_q == $past(i_table_select_poweron_value))
    else $error("table selector missed power-on value");

  a_region_a_denied: assert property (
    i_req.rd && hit_a && priv_q == mamp_pkg::PRIV_NONE |=> o_rdata == 8'h00)
    else $error("region A read without privilege");

  a_region_b_lock: assert property (
    i_req.wr && hit_b && !wr_b |=> $stable(eeprom_q[ee_idx]))
    else $error("region B written without rights");

  a_mask_c_lock: assert property (
    i_req.wr && hit_mask && !wr_c |=> $stable(masks_q))
    else $error("alarm mask written without rights");

  a_mask_table_place: assert property (
    i_req.wr && addr == mamp_pkg::MASK_ENV_ADDR && sel_q != mask_table
    |=> $stable(masks_q.env))
    else $error("alarm mask reached from wrong table");

  a_unmaskable_fault: assert property (
    i_alarms.tx_power_high_alarm |=> o_transmit_fault_interrupt)
    else $error("unmaskable alarm did not raise fault");

  a_bias_max_shutdown: assert property (
    i_alarms.bias_max_alarm && masks_q.signal_bias[3] |=>
    o_laser_shutdown_gate)
    else $error("enabled max-bias alarm did not gate shutdown");

  a_shutdown_masked: assert property (
    !(i_alarms.high_bias_fast_alarm && masks_q.fast_tx[3]) &&
    !(i_alarms.tx_power_high_alarm && masks_q.fast_tx[1]) &&
    !(i_alarms.tx_power_low_alarm && masks_q.fast_tx[0]) &&
    !(i_alarms.bias_max_alarm && masks_q.signal_bias[3])
    |=> !o_laser_shutdown_gate)
    else $error("shutdown raised without enabled fast alarm");

endmodule : mamp_regs

// ===== verilog/mamp_pkg.sv
/*
 * Shared constants and carrier types for the monitor alarm, mask and
 * password register bank. Assumes an I2C slave front end that turns bus
 * transactions into single-byte read and write strobes.
 */
package mamp_pkg;

  // Lower memory map
  localparam logic [7:0] WARN_STATUS_ADDR = 8'h75;
  localparam logic [7:0] GAP_FIRST_ADDR = 8'h76;
  localparam logic [7:0] GAP_LAST_ADDR = 8'h7a;
  localparam logic [7:0] ENTRY_FIRST_ADDR = 8'h7b;
  localparam logic [7:0] ENTRY_LAST_ADDR = 8'h7e;
  localparam logic [7:0] TABLE_SEL_ADDR = 8'h7f;

  // Upper memory map, table one
  localparam logic [7:0] REGION_A_FIRST = 8'h80;
  localparam logic [7:0] REGION_A_LAST = 8'hbf;
  localparam logic [7:0] REGION_B_FIRST = 8'hc0;
  localparam logic [7:0] REGION_B_LAST = 8'hf7;
  localparam logic [7:0] MASK_ENV_ADDR = 8'hf8;
  localparam logic [7:0] MASK_MON34_ADDR = 8'hf9;
  localparam logic [7:0] MASK_FAST_ADDR = 8'hfa;
  localparam logic [7:0] MASK_SIGBIAS_ADDR = 8'hfb;
  localparam logic [7:0] TABLE_ONE = 8'h01;
  localparam logic [7:0] TABLE_MASK_ALT = 8'h05;
  localparam int EEPROM_BYTES = 120;

  // Writable bits of each alarm-enable byte
  localparam logic [7:0] MASK_ENV_WMASK = 8'hff;
  localparam logic [7:0] MASK_MON34_WMASK = 8'hf0;
  localparam logic [7:0] MASK_FAST_WMASK = 8'h0b;
  localparam logic [7:0] MASK_SIGBIAS_WMASK = 8'hc8;

  // Field positions
  localparam int FAST_HIGH_BIAS_BIT = 3;
  localparam int FAST_POWER_HIGH_BIT = 1;
  localparam int FAST_POWER_LOW_BIT = 0;
  localparam int SB_SIGLOSS_HIGH_BIT = 7;
  localparam int SB_SIGLOSS_LOW_BIT = 6;
  localparam int SB_BIAS_MAX_BIT = 3;

  // Reset values
  localparam logic [7:0] WARN_STATUS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] EEPROM_RESET = 8'h00;
  localparam logic [31:0] ENTRY_RESET = 32'hffffffff;
  localparam logic [7:0] READ_ZERO = 8'h00;

  typedef enum logic [1:0] {
    PRIV_NONE = 2'b00,
    PRIV_LOWER = 2'b01,
    PRIV_HIGHER = 2'b10
  } mamp_priv_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mamp_req_type;

  typedef struct packed {
    logic a_read;
    logic a_readwrite;
    logic b_read;
    logic b_readwrite;
    logic c_read;
    logic c_readwrite;
  } mamp_rights_type;

  typedef struct packed {
    logic [7:0] env_alarm;
    logic [3:0] mon34_alarm;
    logic [7:0] env_warning;
    logic high_bias_fast_alarm;
    logic tx_power_high_alarm;
    logic tx_power_low_alarm;
    logic signal_loss_high_alarm;
    logic signal_loss_low_alarm;
    logic bias_max_alarm;
  } mamp_alarms_type;

  typedef struct packed {
    logic monitor_three_high;
    logic monitor_three_low;
    logic monitor_four_high;
    logic monitor_four_low;
  } mamp_mon34_type;

  typedef struct packed {
    logic [7:0] env;
    logic [7:0] mon34;
    logic [7:0] fast_tx;
    logic [7:0] signal_bias;
  } mamp_masks_type;

endpackage : mamp_pkg

// ===== verification/mamp_host.sv
/*
 * Host-side byte access model standing in for the serial slave front end.
 * Assumes one clock and a read answer registered on the taking edge, sampled at the next falling edge.
 */
`timescale 1ns/1ps

module mamp_host (
  // Clock and answer
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  // Byte request
  output mamp_pkg::mamp_req_type o_req
);

  initial begin
    o_req = '0;
  end

  // Released data shows the inverse so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge i_clk);
    o_req.wr = 1'b0;
    o_req.wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    @(negedge i_clk);
    o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge i_clk);
    // Answer pulse stands only one cycle, so take it before release
    d = i_rdata;
    v = i_rvalid;
    o_req.rd = 1'b0;
    o_req.addr = ~a;
  endtask : rd

endmodule : mamp_host

// ===== verification/mamp_regs_tb_top.sv
/*
 * Self-checking bench for the alarm, mask and password register bank.
 * Assumes the host model above and a 50 MHz clock.
 */
`timescale 1ns/1ps

`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, b); end end

module mamp_regs_tb_top;
  localparam logic [31:0] LPW = 32'h12345678;
  localparam logic [31:0] HPW = 32'h9abcdef0;
  localparam logic [7:0] PON = 8'h02;
  logic clk;
  logic rst;
  mamp_pkg::mamp_req_type req;
  logic [7:0] rdata;
  logic rvalid;
  mamp_pkg::mamp_rights_type rights;
  mamp_pkg::mamp_mon34_type flags;
  mamp_pkg::mamp_alarms_type al;
  logic mloc;
  logic mvalid;
  logic fault;
  logic shut;
  logic [1:0] priv;
  logic [7:0] tsel;
  logic nvw;
  logic [15:0] wen;
  int n_mismatch = 0;
  int n_tests = 0;
  logic [7:0] wm [4];

  mamp_host i_mamp_host (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid),
    .o_req(req));

  mamp_regs #(.EEPROM_DEPTH(120)) i_mamp_regs (.i_clk(clk), .i_reset(rst),
    .i_req(req), .o_rdata(rdata), .o_rvalid(rvalid),
    .i_lower_privilege_password(LPW), .i_higher_privilege_password(HPW),
    .i_table_select_poweron_value(PON), .i_mask_location(mloc),
    .i_rights(rights), .i_warning_enable(wen),
    .i_meas_valid(mvalid), .i_mon34_flags(flags), .i_alarms(al),
    .o_transmit_fault_interrupt(fault), .o_laser_shutdown_gate(shut),
    .o_privilege(priv), .o_upper_table_selector(tsel),
    .o_mask_nv_write(nvw));

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    i_mamp_host.rd(a, d, v);
    `CHK(v, 1'b1)
    `CHK(d, e)
  endtask : chk_rd

  // Privilege settles one cycle after the last byte lands
  task automatic pw(input logic [31:0] p);
    for (int i = 0; i < 4; i++) begin
      i_mamp_host.wr(8'h7b + 8'(i), p[31 - 8 * i -: 8]);
    end
    repeat (2) @(negedge clk);
  endtask : pw

  task automatic meas(input logic [3:0] f);
    @(negedge clk);
    flags = f;
    mvalid = 1'b1;
    @(negedge clk);
    mvalid = 1'b0;
  endtask : meas

  task automatic chk_al(input logic f, input logic s);
    @(negedge clk);
    `CHK(fault, f)
    `CHK(shut, s)
  endtask : chk_al

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    #400000;
    n_mismatch++;
    final_report();
  end

  initial begin
    wm = '{mamp_pkg::MASK_ENV_WMASK, mamp_pkg::MASK_MON34_WMASK,
      mamp_pkg::MASK_FAST_WMASK, mamp_pkg::MASK_SIGBIAS_WMASK};
    rst = 1'b1;
    rights = '0;
    flags = '0;
    al = '0;
    mloc = 1'b0;
    wen = 16'h0000;
    mvalid = 1'b0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    `CHK(priv, 2'b00)
    chk_rd(8'h7f, PON);
    `CHK(tsel, PON)
    meas(4'b1001);
    chk_rd(8'h75, 8'h90);
    meas(4'b0110);
    i_mamp_host.wr(8'h75, 8'hff);
    chk_rd(8'h75, 8'h60);
    for (int i = 8'h76; i <= 8'h7a; i++) begin
      i_mamp_host.wr(8'(i), 8'hff);
      chk_rd(8'(i), 8'h00);
    end
    i_mamp_host.wr(8'h7f, 8'h01);
    chk_rd(8'h7f, 8'h01);
    i_mamp_host.wr(8'h80, 8'h5a);
    chk_rd(8'h80, 8'h00);
    chk_rd(8'hf8, 8'h00);
    pw({LPW[7:0], LPW[15:8], LPW[23:16], LPW[31:24]});
    `CHK(priv, 2'b00)
    pw(LPW);
    `CHK(priv, 2'b01)
    chk_rd(8'h7b, 8'h00);
    chk_rd(8'h7e, 8'h00);
    rights.a_readwrite = 1'b1;
    rights.b_read = 1'b1;
    i_mamp_host.wr(8'h80, 8'h5a);
    chk_rd(8'h80, 8'h5a);
    i_mamp_host.wr(8'hc0, 8'h33);
    chk_rd(8'hc0, 8'h00);
    chk_rd(8'hf8, 8'h00);
    i_mamp_host.wr(8'hf8, 8'hff);
    `CHK(nvw, 1'b0)
    rights.c_readwrite = 1'b1;
    i_mamp_host.wr(8'hf8, 8'h81);
    `CHK(nvw, 1'b1)
    rights.c_readwrite = 1'b0;
    rights.c_read = 1'b1;
    i_mamp_host.wr(8'hf8, 8'h18);
    `CHK(nvw, 1'b0)
    chk_rd(8'hf8, 8'h81);
    rights = '0;
    rights.a_read = 1'b1;
    i_mamp_host.wr(8'h80, 8'h11);
    chk_rd(8'h80, 8'h5a);
    rights = '0;
    pw(HPW);
    `CHK(priv, 2'b10)
    i_mamp_host.wr(8'hc0, 8'h33);
    chk_rd(8'hc0, 8'h33);
    chk_rd(8'h80, 8'h5a);
    for (int i = 0; i < 4; i++) begin
      i_mamp_host.wr(8'hf8 + 8'(i), 8'hff);
      `CHK(nvw, 1'b1)
      chk_rd(8'hf8 + 8'(i), wm[i]);
    end
    mloc = 1'b1;
    i_mamp_host.wr(8'h7f, 8'h05);
    chk_rd(8'hf9, 8'hf0);
    i_mamp_host.wr(8'h7f, 8'h01);
    mloc = 1'b0;
    al.env_alarm = 8'h80;
    chk_al(1'b1, 1'b0);
    i_mamp_host.wr(8'hf8, 8'h7f);
    chk_al(1'b0, 1'b0);
    al = '0;
    al.mon34_alarm = 4'h1;
    chk_al(1'b1, 1'b0);
    i_mamp_host.wr(8'hf9, 8'he0);
    chk_al(1'b0, 1'b0);
    al = '0;
    al.signal_loss_low_alarm = 1'b1;
    chk_al(1'b1, 1'b0);
    al = '0;
    al.bias_max_alarm = 1'b1;
    chk_al(1'b1, 1'b1);
    i_mamp_host.wr(8'hfb, 8'h00);
    chk_al(1'b1, 1'b0);
    al = '0;
    al.high_bias_fast_alarm = 1'b1;
    chk_al(1'b1, 1'b1);
    i_mamp_host.wr(8'hfa, 8'h03);
    chk_al(1'b1, 1'b0);
    al = '0;
    al.tx_power_low_alarm = 1'b1;
    chk_al(1'b1, 1'b1);
    al = '0;
    wen = 16'h0040;
    chk_al(1'b1, 1'b0);
    wen = 16'h0100;
    al.env_warning = 8'h01;
    chk_al(1'b1, 1'b0);
    wen = 16'h0020;
    al = '0;
    chk_al(1'b1, 1'b0);
    wen = 16'h0010;
    chk_al(1'b0, 1'b0);
    final_report();
  end

endmodule : mamp_regs_tb_top
